// ===== dpbsc_clocking.sv
`include "dpbsc_params.svh"

module dpbsc_clocking #(
    parameter int WORD_W = `DPBSC_WORD_W,
    parameter int BYTES  = `DPBSC_BYTES,
    parameter int ADDR_W = `DPBSC_ADDR_W
) (
    input  wire logic              I_CLOCK,
    input  wire logic              I_RESET,
    input  wire logic              I_ENABLE,
    input  wire logic              I_K,
    input  wire logic              I_K_N,
    input  wire logic              I_C,
    input  wire logic              I_C_N,
    input  wire logic              I_SINGLE_CLOCK,
    input  wire logic              I_PLL_DISABLE_N,
    input  wire logic              I_READ_PORT_SELECT_N,
    input  wire logic              I_WRITE_PORT_SELECT_N,
    input  wire logic [BYTES-1:0]  I_BYTE_WRITE_SELECT_N,
    input  wire logic [ADDR_W-1:0] I_ADDRESS,
    input  wire logic [WORD_W-1:0] I_DATA,
    output logic      [WORD_W-1:0] O_DATA,
    output logic                   O_DATA_OE,
    output logic                   O_ECHO_CLOCK,
    output logic                   O_ECHO_CLOCK_N
);

    localparam int LINE_W = `DPBSC_BURST_LEN * WORD_W;
    localparam int BE_W   = `DPBSC_BURST_LEN * BYTES;
    localparam int PIN_W  = 8 + BYTES + ADDR_W + WORD_W;

    function automatic logic rise(input logic cur, input logic prev);
        return cur & ~prev;
    endfunction

    function automatic logic [WORD_W-1:0] word_at(
        input logic [LINE_W-1:0] line,
        input logic [1:0]        idx
    );
        return line[idx*WORD_W +: WORD_W];
    endfunction

    // every pin except I_CLOCK, I_RESET and I_ENABLE, the link clocks included, is two-stage synchronised
    logic [PIN_W-1:0]  pin_meta;
    logic [PIN_W-1:0]  pin_sync;
    logic [3:0]        clk_prev;
    logic              s_k, s_kn, s_c, s_cn;
    logic              s_single, s_pll_n, s_rps_n, s_wps_n;
    logic [BYTES-1:0]  s_bws_n;
    logic [ADDR_W-1:0] s_addr;
    logic [WORD_W-1:0] s_data;

    // no reset here: a cleared history would fake a clock rise after it
    always_ff @(posedge I_CLOCK) begin
        if (I_ENABLE) begin
            pin_meta <= {I_K, I_K_N, I_C, I_C_N, I_SINGLE_CLOCK,
                         I_PLL_DISABLE_N, I_READ_PORT_SELECT_N,
                         I_WRITE_PORT_SELECT_N, I_BYTE_WRITE_SELECT_N,
                         I_ADDRESS, I_DATA};
            pin_sync <= pin_meta;
            clk_prev <= pin_sync[PIN_W-1 -: 4];
        end
    end

    assign {s_k, s_kn, s_c, s_cn, s_single, s_pll_n, s_rps_n, s_wps_n,
            s_bws_n, s_addr, s_data} = pin_sync;

    logic       k_rise, kn_rise, out_pos_rise, out_neg_rise;
    logic       out_edge, start_rd, start_wr;
    logic [1:0] lat_edges;

    assign k_rise       = rise(s_k, clk_prev[3]);
    assign kn_rise      = rise(s_kn, clk_prev[2]);
    assign out_pos_rise = s_single ? k_rise
                                   : rise(s_c, clk_prev[1]);
    assign out_neg_rise = s_single ? kn_rise
                                   : rise(s_cn, clk_prev[0]);
    assign out_edge     = out_pos_rise | out_neg_rise;
    assign lat_edges    = s_pll_n ? `DPBSC_LAT_EDGES_PLL_ON
                                  : `DPBSC_LAT_EDGES_PLL_OFF;

    // read wins a tie unless it started on the previous rise
    logic read_last, next_read_last;
    logic write_last, next_write_last;
    assign start_rd = k_rise & ~s_rps_n & ~read_last;
    assign start_wr = k_rise & ~s_wps_n & ~write_last & ~start_rd;

    // read side
    logic                       rd_fetch, next_rd_fetch;
    logic                       rd_pend, next_rd_pend;
    logic [1:0]                 rd_cnt, next_rd_cnt;
    logic [LINE_W-1:0]          rd_pend_line, next_rd_pend_line;
    logic [LINE_W-1:0]          rd_buf, next_rd_buf;
    logic [1:0]                 rd_beat, next_rd_beat;
    dpbsc_pkg::dpbsc_rd_state_t rd_state, next_rd_state;
    logic [WORD_W-1:0]          next_data;
    logic                       next_oe, next_echo, next_echo_n;
    logic [LINE_W-1:0]          mem_rdata;

    always_comb begin
        next_read_last    = read_last;
        next_rd_fetch     = start_rd;
        next_rd_pend      = rd_pend;
        next_rd_cnt       = rd_cnt;
        next_rd_pend_line = rd_pend_line;
        next_rd_buf       = rd_buf;
        next_rd_beat      = rd_beat;
        next_rd_state     = rd_state;
        next_data         = O_DATA;
        next_oe           = O_DATA_OE;
        next_echo         = s_single ? s_k : s_c;
        next_echo_n       = s_single ? s_kn : s_cn;
        if (k_rise) begin
            next_read_last = start_rd;
        end
        if (rd_fetch) begin
            next_rd_pend_line = mem_rdata;
        end
        if (out_edge) begin
            if (rd_pend && (rd_cnt + 2'h1 == lat_edges)) begin
                next_rd_buf   = rd_pend_line;
                next_data     = word_at(rd_pend_line, 2'h0);
                next_oe       = 1'b1;
                next_rd_state = dpbsc_pkg::RD_BURST;
                next_rd_beat  = 2'h1;
                next_rd_pend  = 1'b0;
            end else begin
                if (rd_pend) begin
                    next_rd_cnt = rd_cnt + 2'h1;
                end
                unique case (rd_state)
                    dpbsc_pkg::RD_IDLE: begin
                        next_oe = 1'b0;
                    end
                    dpbsc_pkg::RD_BURST: begin
                        next_data    = word_at(rd_buf, rd_beat);
                        next_rd_beat = rd_beat + 2'h1;
                        if (rd_beat == 2'h3) begin
                            next_rd_state = dpbsc_pkg::RD_HOLD;
                        end
                    end
                    dpbsc_pkg::RD_HOLD: begin
                        // outputs stay driven until a positive output rise
                        if (out_pos_rise) begin
                            next_oe       = 1'b0;
                            next_rd_state = dpbsc_pkg::RD_IDLE;
                        end
                    end
                endcase
            end
        end
        if (start_rd) begin
            next_rd_pend = 1'b1;
            next_rd_cnt  = 2'h0;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (I_RESET) begin
            read_last      <= 1'b0;
            rd_fetch       <= 1'b0;
            rd_pend        <= 1'b0;
            rd_cnt         <= 2'h0;
            rd_pend_line   <= '0;
            rd_buf         <= '0;
            rd_beat        <= 2'h0;
            rd_state       <= dpbsc_pkg::RD_IDLE;
            O_DATA         <= WORD_W'(`DPBSC_DATA_RESET);
            O_DATA_OE      <= 1'b0;
            O_ECHO_CLOCK   <= 1'b0;
            O_ECHO_CLOCK_N <= 1'b0;
        end else if (I_ENABLE) begin
            read_last      <= next_read_last;
            rd_fetch       <= next_rd_fetch;
            rd_pend        <= next_rd_pend;
            rd_cnt         <= next_rd_cnt;
            rd_pend_line   <= next_rd_pend_line;
            rd_buf         <= next_rd_buf;
            rd_beat        <= next_rd_beat;
            rd_state       <= next_rd_state;
            O_DATA         <= next_data;
            O_DATA_OE      <= next_oe;
            O_ECHO_CLOCK   <= next_echo;
            O_ECHO_CLOCK_N <= next_echo_n;
        end
    end

    // write side: address waits one rise, then four words are gathered
    logic              wp_valid, next_wp_valid, wc_active, next_wc_active;
    logic [ADDR_W-1:0] wp_addr, next_wp_addr;
    logic [1:0]        wc_beat, next_wc_beat;
    logic [ADDR_W-1:0] wc_addr, next_wc_addr;
    logic [LINE_W-1:0] wc_line, next_wc_line;
    logic [BE_W-1:0]   wc_be, next_wc_be;
    logic              mem_wr, next_mem_wr;

    always_comb begin
        next_write_last = write_last;
        next_wp_valid   = wp_valid;
        next_wp_addr    = wp_addr;
        next_wc_active  = wc_active;
        next_wc_beat    = wc_beat;
        next_wc_addr    = wc_addr;
        next_wc_line    = wc_line;
        next_wc_be      = wc_be;
        next_mem_wr     = 1'b0;
        if (k_rise) begin
            next_write_last = start_wr;
            if (wc_active && wc_beat == 2'h2) begin
                next_wc_line[2*WORD_W +: WORD_W] = s_data;
                next_wc_be[2*BYTES +: BYTES]     = ~s_bws_n;
                next_wc_beat                     = 2'h3;
            end
            if (wp_valid) begin
                next_wc_addr                 = wp_addr;
                next_wc_line[0 +: WORD_W]    = s_data;
                next_wc_be                   = '0;
                next_wc_be[0 +: BYTES]       = ~s_bws_n;
                next_wc_active               = 1'b1;
                next_wc_beat                 = 2'h1;
                next_wp_valid                = 1'b0;
            end
        end
        if (kn_rise && wc_active && wc_beat[0]) begin
            next_wc_line[wc_beat*WORD_W +: WORD_W] = s_data;
            next_wc_be[wc_beat*BYTES +: BYTES]     = ~s_bws_n;
            next_wc_beat                           = wc_beat + 2'h1;
            if (wc_beat == 2'h3) begin
                next_wc_active = 1'b0;
                next_mem_wr    = 1'b1;
            end
        end
        if (start_wr) begin
            next_wp_valid = 1'b1;
            next_wp_addr  = s_addr;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (I_RESET) begin
            write_last <= 1'b0;
            wp_valid   <= 1'b0;
            wp_addr    <= '0;
            wc_active  <= 1'b0;
            wc_beat    <= 2'h0;
            wc_addr    <= '0;
            wc_line    <= '0;
            wc_be      <= '0;
            mem_wr     <= 1'b0;
        end else if (I_ENABLE) begin
            write_last <= next_write_last;
            wp_valid   <= next_wp_valid;
            wp_addr    <= next_wp_addr;
            wc_active  <= next_wc_active;
            wc_beat    <= next_wc_beat;
            wc_addr    <= next_wc_addr;
            wc_line    <= next_wc_line;
            wc_be      <= next_wc_be;
            mem_wr     <= next_mem_wr;
        end
    end

    // read address goes straight from the shared bus to the array
    dpbsc_mem #(
        .WORD_W (WORD_W),
        .BYTES  (BYTES),
        .ADDR_W (ADDR_W)
    ) dpbsc_mem_i (
        .i_clock      (I_CLOCK),
        .i_reset      (I_RESET),
        .i_enable     (I_ENABLE),
        .i_wr_en      (mem_wr),
        .i_wr_addr    (wc_addr),
        .i_wr_data    (wc_line),
        .i_wr_byte_en (wc_be),
        .i_rd_en      (start_rd),
        .i_rd_addr    (s_addr),
        .o_rd_data    (mem_rdata)
    );

endmodule // dpbsc_clocking

// ===== dpbsc_params.svh
`ifndef DPBSC_PARAMS_SVH
`define DPBSC_PARAMS_SVH

`define DPBSC_BURST_LEN         4
`define DPBSC_WORD_W            18
`define DPBSC_BYTES             2
`define DPBSC_ADDR_W            4
// read latency counted in output-clock half cycles after the capture
`define DPBSC_LAT_EDGES_PLL_ON  2'h3
`define DPBSC_LAT_EDGES_PLL_OFF 2'h2
// highest link clock the far end may use with the pll turned off
`define DPBSC_PLL_OFF_MAX_MHZ   167
`define DPBSC_DATA_RESET        'h0

`endif

// ===== dpbsc_pkg.sv
package dpbsc_pkg;

    typedef enum logic [1:0] {
        RD_IDLE,
        RD_BURST,
        RD_HOLD
    } dpbsc_rd_state_t;

endpackage

// ===== dpbsc_mem.sv
`include "dpbsc_params.svh"

module dpbsc_mem #(
    parameter int WORD_W = `DPBSC_WORD_W,
    parameter int BYTES  = `DPBSC_BYTES,
    parameter int ADDR_W = `DPBSC_ADDR_W
) (
    input  wire logic                                i_clock,
    input  wire logic                                i_reset,
    input  wire logic                                i_enable,
    input  wire logic                                i_wr_en,
    input  wire logic [ADDR_W-1:0]                   i_wr_addr,
    input  wire logic [`DPBSC_BURST_LEN*WORD_W-1:0]  i_wr_data,
    input  wire logic [`DPBSC_BURST_LEN*BYTES-1:0]   i_wr_byte_en,
    input  wire logic                                i_rd_en,
    input  wire logic [ADDR_W-1:0]                   i_rd_addr,
    output logic      [`DPBSC_BURST_LEN*WORD_W-1:0]  o_rd_data
);

    localparam int LINE_W = `DPBSC_BURST_LEN * WORD_W;
    localparam int LANES  = `DPBSC_BURST_LEN * BYTES;
    localparam int LANE_W = WORD_W / BYTES;

    logic [LINE_W-1:0] store [2**ADDR_W];

    // a lane left unselected keeps its old contents
    always_ff @(posedge i_clock) begin
        if (i_enable && i_wr_en) begin
            for (int i = 0; i < LANES; i++) begin
                if (i_wr_byte_en[i]) begin
                    store[i_wr_addr][i*LANE_W +: LANE_W] <=
                        i_wr_data[i*LANE_W +: LANE_W];
                end
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_rd_data <= '0;
        end else if (i_enable && i_rd_en) begin
            o_rd_data <= store[i_rd_addr];
        end
    end

endmodule // dpbsc_mem

// ===== dpbsc_clocking_chk.sv
module dpbsc_clocking_chk #(
    parameter int WORD_W = 18
) (
    input  wire logic              I_CLOCK,
    input  wire logic              I_RESET,
    input  wire logic              I_K,
    input  wire logic              I_K_N,
    input  wire logic              I_C,
    input  wire logic              I_C_N,
    input  wire logic              I_SINGLE_CLOCK,
    input  wire logic              I_PLL_DISABLE_N,
    input  wire logic              I_READ_PORT_SELECT_N,
    input  wire logic [WORD_W-1:0] O_DATA,
    input  wire logic              O_DATA_OE,
    input  wire logic              O_ECHO_CLOCK,
    input  wire logic              O_ECHO_CLOCK_N
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (I_RESET);
    logic       pin_p;
    logic       pin_n;
    logic [5:0] since_rd;
    logic [5:0] next_since_rd;
    logic [3:0] up;
    logic [3:0] next_up;
    assign pin_p = I_SINGLE_CLOCK ? I_K : I_C;
    assign pin_n = I_SINGLE_CLOCK ? I_K_N : I_C_N;
    // pin history is trusted only once the synchronisers have refilled
    always_comb begin
        next_up = (up == 4'hf) ? up : up + 4'h1;
        next_since_rd = (since_rd == 6'h3f) ? since_rd : since_rd + 6'h1;
        if (I_RESET) begin
            next_up = 4'h0;
            next_since_rd = 6'h3f;
        end else if (!I_READ_PORT_SELECT_N) begin
            next_since_rd = 6'h0;
        end
    end
    always_ff @(posedge I_CLOCK) begin
        up <= next_up;
        since_rd <= next_since_rd;
    end
    sequence words_s;
        O_DATA_OE [*8] ##1 O_DATA_OE [*7];
    endsequence
    echo_pos_a:
        assert property (up == 4'hf && $rose(O_ECHO_CLOCK)
            |-> $past(pin_p, 2) && !$past(pin_p, 6))
        else $error("echo rise not tied to its clock pin");
    echo_neg_a:
        assert property (up == 4'hf && $rose(O_ECHO_CLOCK_N)
            |-> $past(pin_n, 2) && !$past(pin_n, 6))
        else $error("inverted echo rise not tied to its clock pin");
    echo_alive_a:
        assert property (up == 4'hf && $changed(O_ECHO_CLOCK)
            |-> ##[3:5] $changed(O_ECHO_CLOCK))
        else $error("echo clock stopped");
    rd_cause_a:
        assert property ($rose(O_DATA_OE) |-> since_rd <= 6'h10)
        else $error("output driven without a read request");
    burst_len_a:
        assert property ($rose(O_DATA_OE) |-> words_s ##[1:7] !O_DATA_OE)
        else $error("read burst length wrong");
    idle_release_a:
        assert property (since_rd > 6'h24 |-> !O_DATA_OE)
        else $error("output still driven long after reads");
    drop_edge_a:
        assert property ($fell(O_DATA_OE) |-> $rose(O_ECHO_CLOCK))
        else $error("output released off the positive clock");
    data_edge_a:
        assert property (O_DATA_OE && $past(O_DATA_OE) && $changed(O_DATA)
            |-> $changed(O_ECHO_CLOCK))
        else $error("read data changed off an output edge");
    start_edge_a:
        assert property ($rose(O_DATA_OE) |-> (I_PLL_DISABLE_N ?
            $fell(O_ECHO_CLOCK) : $rose(O_ECHO_CLOCK)))
        else $error("first read word on wrong output edge");
endmodule // dpbsc_clocking_chk

// ===== dpbsc_ctrl_model.sv
module dpbsc_ctrl_model (
    input  wire logic i_c_run,
    output logic      o_k,
    output logic      o_k_n,
    output logic      o_c,
    output logic      o_c_n
);
    timeunit 1ns;
    timeprecision 1ns;
    // 800 ns period stays far below the pll-off ceiling
    initial begin
        o_k = 1'b0;
        #37;
        forever #400 o_k = ~o_k;
    end
    assign o_k_n = ~o_k;
    // output clocks stand still when single clock mode leaves them unused
    assign o_c   = i_c_run & o_k;
    assign o_c_n = i_c_run & o_k_n;
endmodule // dpbsc_ctrl_model

// ===== dpbsc_clocking_tb.sv
`include "dpbsc_params.svh"

module dpbsc_clocking_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int WW = `DPBSC_WORD_W;
    localparam int NB = `DPBSC_BYTES;
    localparam int AW = `DPBSC_ADDR_W;
    localparam int BW = WW / NB;
    logic          clk, rst, sc, pll, rs_n, ws_n, c_run;
    logic          k, k_n, c, c_n, oe, eq, eq_n;
    logic [NB-1:0] bw_n;
    logic [AW-1:0] addr;
    logic [WW-1:0] din, dout;
    logic [WW-1:0] mem [16][4];
    int            fails, cmp_count, cycles;

    dpbsc_ctrl_model dpbsc_ctrl_model_i (.i_c_run(c_run), .o_k(k),
        .o_k_n(k_n), .o_c(c), .o_c_n(c_n));
    dpbsc_clocking dpbsc_clocking_i (.I_CLOCK(clk), .I_RESET(rst),
        .I_ENABLE(1'b1), .I_K(k), .I_K_N(k_n), .I_C(c), .I_C_N(c_n),
        .I_SINGLE_CLOCK(sc), .I_PLL_DISABLE_N(pll),
        .I_READ_PORT_SELECT_N(rs_n), .I_WRITE_PORT_SELECT_N(ws_n),
        .I_BYTE_WRITE_SELECT_N(bw_n), .I_ADDRESS(addr), .I_DATA(din),
        .O_DATA(dout), .O_DATA_OE(oe), .O_ECHO_CLOCK(eq),
        .O_ECHO_CLOCK_N(eq_n));

    task test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task cmp(input string what, input logic [WW-1:0] exp,
             input logic [WW-1:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    // modes only change under reset so every block restarts cleanly
    task mode(input logic s, input logic p);
        @(negedge clk);
        rst = 1'b1;
        sc = s;
        pll = p;
        c_run = !s;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        repeat (8) @(negedge clk);
        cmp("reset drive", '0, oe);
    endtask

    // values change mid half period, well away from the sampled link edge
    task put(input logic rise, input logic r_n, input logic w_n,
             input logic [NB-1:0] b_n, input logic [AW-1:0] a,
             input logic [WW-1:0] d);
        if (rise) begin
            @(posedge k_n);
        end else begin
            @(posedge k);
        end
        repeat (2) @(negedge clk);
        rs_n = r_n;
        ws_n = w_n;
        bw_n = b_n;
        addr = a;
        din = d;
    endtask

    task automatic wr(input logic [AW-1:0] a, input logic [NB-1:0] b_n,
                      input logic [WW-1:0] d0);
        logic [WW-1:0] dv;
        put(1'b1, 1'b1, 1'b0, '1, a, '0);
        for (int i = 0; i < 4; i++) begin
            dv = d0 + WW'(i);
            put(i % 2 == 0, 1'b1, 1'b1, b_n, '0, dv);
            for (int j = 0; j < NB; j++) begin
                if (!b_n[j]) begin
                    mem[a][i][j*BW +: BW] = dv[j*BW +: BW];
                end
            end
        end
        put(1'b1, 1'b1, 1'b1, '1, '0, '0);
    endtask

    task automatic rd(input logic [AW-1:0] a, input logic twice);
        time t0;
        int  hc;
        hc = pll ? 3 : 2;
        put(1'b1, 1'b0, 1'b1, '1, a, '0);
        @(posedge k);
        t0 = $time;
        fork
            begin
                put(1'b1, !twice, 1'b1, '1, a ^ AW'(1), '0);
                put(1'b1, 1'b1, 1'b1, '1, '0, '0);
            end
            begin
                for (int i = 0; i < 4; i++) begin
                    #(t0 + (hc + i) * 400 + 250 - $time);
                    cmp("read word", mem[a][i], dout);
                    cmp("read drive", 1, oe);
                end
                #(t0 + (2 * hc + 2) * 400 + 250 - $time);
                cmp("read release", 0, oe);
            end
        join
    endtask

    // echo pair seen shortly after each link edge, with no read running
    task automatic echo_chk;
        @(posedge k);
        #250;
        cmp("echo clock", 1, eq);
        cmp("inverted echo", 0, eq_n);
        @(posedge k_n);
        #250;
        cmp("echo clock", 0, eq);
        cmp("inverted echo", 1, eq_n);
    endtask

    task t_basic;
        mode(1'b0, 1'b1);
        wr(4'h5, '0, 18'h2a5a5);
        wr(4'h4, '0, 18'h1c3c3);
        rd(4'h5, 1'b0);
        rd(4'h4, 1'b0);
        $display("test basic done");
    endtask

    task t_pll_off;
        mode(1'b0, 1'b0);
        wr(4'h9, '0, 18'h0f0f0);
        rd(4'h9, 1'b0);
        $display("test pll off done");
    endtask

    task t_bytes;
        mode(1'b0, 1'b1);
        wr(4'h3, '0, 18'h11111);
        wr(4'h3, 2'h2, 18'h3eeee);
        rd(4'h3, 1'b0);
        $display("test byte selects done");
    endtask

    task t_twice;
        mode(1'b0, 1'b1);
        wr(4'h6, '0, 18'h01234);
        wr(4'h7, '0, 18'h3cdef);
        rd(4'h6, 1'b1);
        $display("test repeated read done");
    endtask

    task t_single;
        mode(1'b1, 1'b1);
        wr(4'h2, '0, 18'h25555);
        rd(4'h2, 1'b0);
        echo_chk();
        $display("test single clock done");
    endtask

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            test_done();
        end
    end

    initial begin
        rst = 1'b1;
        sc = 1'b0;
        pll = 1'b1;
        c_run = 1'b1;
        rs_n = 1'b1;
        ws_n = 1'b1;
        bw_n = '1;
        addr = '0;
        din = '0;
        t_basic();
        t_pll_off();
        t_bytes();
        t_twice();
        t_single();
        test_done();
    end
endmodule // dpbsc_clocking_tb

bind dpbsc_clocking dpbsc_clocking_chk #(.WORD_W(WORD_W)) chk_i (
    .I_CLOCK(I_CLOCK), .I_RESET(I_RESET), .I_K(I_K), .I_K_N(I_K_N),
    .I_C(I_C), .I_C_N(I_C_N), .I_SINGLE_CLOCK(I_SINGLE_CLOCK),
    .I_PLL_DISABLE_N(I_PLL_DISABLE_N),
    .I_READ_PORT_SELECT_N(I_READ_PORT_SELECT_N), .O_DATA(O_DATA),
    .O_DATA_OE(O_DATA_OE), .O_ECHO_CLOCK(O_ECHO_CLOCK),
    .O_ECHO_CLOCK_N(O_ECHO_CLOCK_N));
